// ---- src/wire_host_pkg.sv ----
// Constants, register map and timing of the single-wire bus master.
package wire_host_pkg;

    // Clock rate and the width of every cycle counter.
    localparam int unsigned CLK_HZ  = 200_000_000;
    localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int unsigned CW      = 21;
    typedef logic [CW-1:0] cnt_t;

    // Pulse and slot times in microseconds, bit rates in bits per second.
    localparam int unsigned RST_REG_US    = 480;
    localparam int unsigned RST_FAST_US   = 48;
    localparam int unsigned PRES_REG_US   = 70;
    localparam int unsigned PRES_FAST_US  = 8;
    localparam int unsigned W0_REG_US     = 60;
    localparam int unsigned W0_FAST_US    = 6;
    localparam int unsigned W1_REG_US     = 6;
    localparam int unsigned W1_FAST_US    = 1;
    localparam int unsigned RDS_REG_US    = 13;
    localparam int unsigned RDS_FAST_US   = 2;
    localparam int unsigned RATE_REG_BPS  = 16300;
    localparam int unsigned RATE_FAST_BPS = 142000;
    localparam int unsigned COPY_WAIT_MS  = 5;

    // Cycle counts; a slot is the shortest that keeps the rate limit.
    localparam int unsigned RST_REG_CYC   = RST_REG_US * CLK_MHZ;
    localparam int unsigned RST_FAST_CYC  = RST_FAST_US * CLK_MHZ;
    localparam int unsigned PRES_REG_CYC  = PRES_REG_US * CLK_MHZ;
    localparam int unsigned PRES_FAST_CYC = PRES_FAST_US * CLK_MHZ;
    localparam int unsigned W0_REG_CYC    = W0_REG_US * CLK_MHZ;
    localparam int unsigned W0_FAST_CYC   = W0_FAST_US * CLK_MHZ;
    localparam int unsigned W1_REG_CYC    = W1_REG_US * CLK_MHZ;
    localparam int unsigned W1_FAST_CYC   = W1_FAST_US * CLK_MHZ;
    localparam int unsigned RDS_REG_CYC   = RDS_REG_US * CLK_MHZ;
    localparam int unsigned RDS_FAST_CYC  = RDS_FAST_US * CLK_MHZ;
    localparam int unsigned SLOT_REG_CYC  =
        (CLK_HZ + RATE_REG_BPS - 1) / RATE_REG_BPS;
    localparam int unsigned SLOT_FAST_CYC =
        (CLK_HZ + RATE_FAST_BPS - 1) / RATE_FAST_BPS;
    localparam int unsigned COPY_WAIT_CYC = COPY_WAIT_MS * (CLK_HZ / 1000);

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_TXDATA = 8'h04;
    localparam logic [7:0] OFS_RXDATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // Control register fields and operation codes.
    localparam int unsigned CTRL_DIR_BIT  = 8;
    localparam int unsigned CTRL_LONG_BIT = 9;
    localparam logic [2:0] OP_RESET = 3'h1;
    localparam logic [2:0] OP_WRITE = 3'h2;
    localparam logic [2:0] OP_READ  = 3'h3;
    localparam logic [2:0] OP_TRIP  = 3'h4;
    localparam logic [2:0] OP_WAIT  = 3'h5;

    // Identity command codes.
    localparam logic [7:0] ROM_READ       = 8'h33;
    localparam logic [7:0] ROM_MATCH      = 8'h55;
    localparam logic [7:0] ROM_SKIP       = 8'hCC;
    localparam logic [7:0] ROM_SEARCH     = 8'hF0;
    localparam logic [7:0] ROM_FAST_SKIP  = 8'h3C;
    localparam logic [7:0] ROM_FAST_MATCH = 8'h69;

    // Transaction phases.
    typedef enum logic [1:0] {PH_NONE, PH_ROM, PH_MEM} phase_t;

endpackage

// ---- src/line_sync.sv ----
// Two-stage synchroniser for the bus line input.
`timescale 1ns/1ps
module line_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Raw and synchronised level
    input  wire logic din,
    output logic      dout
);
    logic meta_reg;

    // The line idles high, so both stages reset to one.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= 1'b1;
            dout     <= 1'b1;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule

// ---- src/bit_slot.sv ----
// One timed line window: pull low, sample once, release until the end.
`timescale 1ns/1ps
module bit_slot (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Window request and its timing in cycles
    input  wire logic                 start,
    input  wire wire_host_pkg::cnt_t  low_cyc,
    input  wire wire_host_pkg::cnt_t  smp_cyc,
    input  wire wire_host_pkg::cnt_t  end_cyc,
    // Line
    input  wire logic                 line_lvl,
    output logic                      drive_low,
    // Result
    output logic                      sample,
    output logic                      done
);
    logic                busy_reg;
    wire_host_pkg::cnt_t cnt_reg;
    logic                busy_next;
    wire_host_pkg::cnt_t cnt_next;

    // Next count and activity of the window.
    always_comb begin
        busy_next = busy_reg;
        cnt_next  = cnt_reg;
        if (start) begin
            busy_next = 1'b1;
            cnt_next  = '0;
        end else if (busy_reg) begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_next == end_cyc) begin
                busy_next = 1'b0;
            end
        end
    end

    // Counter, registered drive, sample and end pulse.
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_reg  <= 1'b0;
            cnt_reg   <= '0;
            drive_low <= 1'b0;
            sample    <= 1'b1;
            done      <= 1'b0;
        end else begin
            busy_reg  <= busy_next;
            cnt_reg   <= cnt_next;
            drive_low <= busy_next && (cnt_next < low_cyc);
            done      <= busy_reg && !busy_next;
            if (busy_reg && cnt_reg == smp_cyc) begin
                sample <= line_lvl;
            end
        end
    end
endmodule

// ---- src/wire_host.sv ----
// Single-wire bus master with an APB register interface.
//
// Functional notes
// - Order: initialization, identity command, memory command, data.
// - Initialization is a master reset pulse answered by slave presence.
// - After presence, one of six eight-bit identity commands is sent.
// - Master uses identity read only with a single slave attached.
// - Code F0h: per bit, send bit and complement, sample master choice.
// - After broadcast fast skip: fast reset, then match or search.
// - Line idles high; long low periods act as resets.
// - A paused transaction leaves the line released high.
// - All parties drive open-drain, giving a wired-AND.
// - Every bit slot starts with a master falling edge.
// - Bit rate at most 16.3kbps regular and 142kbps fast.
// - Scratchpad write: 0Fh, low address, high address, data, LSB first.
// - Copy: 55h, three authorization bytes, then 5ms with line idle.
// - Memory read F0h: two address bytes, then up to 512 data bytes.
// - Regular-speed reset pulse lasts 480us to 960us.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module wire_host #(
    parameter int unsigned RST_REG_P   = wire_host_pkg::RST_REG_CYC,
    parameter int unsigned RST_FAST_P  = wire_host_pkg::RST_FAST_CYC,
    parameter int unsigned PRES_REG_P  = wire_host_pkg::PRES_REG_CYC,
    parameter int unsigned W0_REG_P    = wire_host_pkg::W0_REG_CYC,
    parameter int unsigned SLOT_REG_P  = wire_host_pkg::SLOT_REG_CYC,
    parameter int unsigned COPY_WAIT_P = wire_host_pkg::COPY_WAIT_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Open-drain bus line
    input  wire logic        line_in,
    output logic             line_out,
    output logic             line_oe
);
    typedef enum {ST_IDLE, ST_RESET, ST_BYTE, ST_TRIP, ST_WAIT} state_t;

    // Write-1 low time and read sample point follow the write-0 time, so a
    // shortened regular slot keeps its proportions.
    localparam int unsigned W1_REG_L  =
        W0_REG_P * wire_host_pkg::W1_REG_US / wire_host_pkg::W0_REG_US;
    localparam int unsigned RDS_REG_L =
        W0_REG_P * wire_host_pkg::RDS_REG_US / wire_host_pkg::W0_REG_US;

    state_t                state_reg;
    wire_host_pkg::phase_t phase_reg;
    logic                  fast_speed_flag;
    logic                  presence_reg;
    logic                  order_err_reg;
    logic                  refused_reg;
    logic                  long_reg;
    logic                  dir_reg;
    logic                  is_write_reg;
    logic [7:0]            tx_reg;
    logic [7:0]            shift_reg;
    logic [7:0]            rx_reg;
    logic [2:0]            bit_idx_reg;
    logic [1:0]            step_reg;
    logic                  trip_id_reg;
    logic                  trip_cmp_reg;
    logic                  trip_chosen_reg;
    logic                  start_reg;
    wire_host_pkg::cnt_t   low_reg;
    wire_host_pkg::cnt_t   smp_reg;
    wire_host_pkg::cnt_t   end_reg;

    logic                  line_lvl;
    logic                  slot_low;
    logic                  slot_sample;
    logic                  slot_done;
    logic                  wr_ctrl;
    logic                  wr_tx;
    logic [2:0]            op;
    logic                  op_ok;
    logic                  mapped;
    logic                  next_bit;
    logic                  chosen;

    // Line input is resynchronised before any logic looks at it.
    line_sync u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (line_in),
        .dout (line_lvl)
    );

    // Timed window generator shared by reset, bit slots and copy wait.
    bit_slot u_slot (
        .clk       (clk),
        .rst       (rst),
        .start     (start_reg),
        .low_cyc   (low_reg),
        .smp_cyc   (smp_reg),
        .end_cyc   (end_reg),
        .line_lvl  (line_lvl),
        .drive_low (slot_low),
        .sample    (slot_sample),
        .done      (slot_done)
    );

    // The master only ever pulls low; the pull-up makes the high level.
    assign line_out = 1'b0;
    assign line_oe  = slot_low;

    // APB answers at once; an unmapped offset signals an error.
    assign pready  = 1'b1;
    assign mapped  = (paddr == wire_host_pkg::OFS_CTRL)   ||
                     (paddr == wire_host_pkg::OFS_TXDATA) ||
                     (paddr == wire_host_pkg::OFS_RXDATA) ||
                     (paddr == wire_host_pkg::OFS_STATUS);
    assign pslverr = psel && penable && !mapped;
    assign wr_ctrl = psel && penable && pwrite &&
                     (paddr == wire_host_pkg::OFS_CTRL);
    assign wr_tx   = psel && penable && pwrite &&
                     (paddr == wire_host_pkg::OFS_TXDATA);
    assign op      = pwdata[2:0];

    // An operation is taken only when idle and in a legal phase.
    always_comb begin
        op_ok = 1'b0;
        if (state_reg == ST_IDLE) begin
            unique case (op)
                wire_host_pkg::OP_RESET: op_ok = 1'b1;
                wire_host_pkg::OP_WRITE:
                    op_ok = (phase_reg != wire_host_pkg::PH_NONE);
                wire_host_pkg::OP_READ,
                wire_host_pkg::OP_TRIP:
                    op_ok = (phase_reg == wire_host_pkg::PH_MEM);
                wire_host_pkg::OP_WAIT: op_ok = 1'b1;
                default: op_ok = 1'b0;
            endcase
        end
    end

    // Search choice: a differing pair names the bit, else take the hint.
    assign chosen = (trip_id_reg != trip_cmp_reg) ? trip_id_reg : dir_reg;

    // Bit of the next byte slot: data LSB first, or a read slot.
    assign next_bit = is_write_reg ? shift_reg[1] : 1'b1;

    // Registered read data, loaded in the setup phase.
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                wire_host_pkg::OFS_CTRL:
                    prdata <= {22'h00_0000, long_reg, dir_reg, 8'h00};
                wire_host_pkg::OFS_TXDATA:
                    prdata <= {24'h00_0000, tx_reg};
                wire_host_pkg::OFS_RXDATA:
                    prdata <= {24'h00_0000, rx_reg};
                wire_host_pkg::OFS_STATUS:
                    prdata <= {22'h00_0000, trip_chosen_reg, trip_cmp_reg,
                               trip_id_reg, refused_reg, order_err_reg,
                               phase_reg, fast_speed_flag, presence_reg,
                               (state_reg != ST_IDLE)};
                default:
                    prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Transmit byte and operation options held by software.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_reg   <= 8'h00;
            dir_reg  <= 1'b0;
            long_reg <= 1'b0;
        end else begin
            if (wr_tx) begin
                tx_reg <= pwdata[7:0];
            end
            if (wr_ctrl) begin
                dir_reg  <= pwdata[wire_host_pkg::CTRL_DIR_BIT];
                long_reg <= pwdata[wire_host_pkg::CTRL_LONG_BIT];
            end
        end
    end

    // Sticky error flags, cleared by the next accepted reset operation.
    always_ff @(posedge clk) begin
        if (rst) begin
            order_err_reg <= 1'b0;
            refused_reg   <= 1'b0;
        end else if (wr_ctrl) begin
            if (state_reg != ST_IDLE) begin
                refused_reg <= 1'b1;
            end else if (!op_ok) begin
                order_err_reg <= 1'b1;
            end else if (op == wire_host_pkg::OP_RESET) begin
                order_err_reg <= 1'b0;
                refused_reg   <= 1'b0;
            end
        end
    end

    // Sequencer: launches each timed window and collects its result.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg       <= ST_IDLE;
            start_reg       <= 1'b0;
            low_reg         <= '0;
            smp_reg         <= '0;
            end_reg         <= '0;
            is_write_reg    <= 1'b0;
            shift_reg       <= 8'h00;
            bit_idx_reg     <= 3'h0;
            step_reg        <= 2'h0;
            trip_id_reg     <= 1'b0;
            trip_cmp_reg    <= 1'b0;
            trip_chosen_reg <= 1'b0;
            rx_reg          <= 8'h00;
        end else begin
            start_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (wr_ctrl && op_ok) begin
                        start_reg <= 1'b1;
                        unique case (op)
                            wire_host_pkg::OP_RESET: begin
                                state_reg <= ST_RESET;
                                if (fast_speed_flag && !pwdata[
                                        wire_host_pkg::CTRL_LONG_BIT]) begin
                                    low_reg <= cw(RST_FAST_P);
                                    smp_reg <= cw(RST_FAST_P +
                                        wire_host_pkg::PRES_FAST_CYC);
                                    end_reg <= cw(2 * RST_FAST_P);
                                end else begin
                                    low_reg <= cw(RST_REG_P);
                                    smp_reg <= cw(RST_REG_P + PRES_REG_P);
                                    end_reg <= cw(2 * RST_REG_P);
                                end
                            end
                            wire_host_pkg::OP_WAIT: begin
                                state_reg <= ST_WAIT;
                                low_reg   <= '0;
                                smp_reg   <= '0;
                                end_reg   <= cw(COPY_WAIT_P);
                            end
                            wire_host_pkg::OP_TRIP: begin
                                state_reg <= ST_TRIP;
                                step_reg  <= 2'h0;
                                load_slot(1'b1);
                            end
                            default: begin
                                state_reg    <= ST_BYTE;
                                bit_idx_reg  <= 3'h0;
                                is_write_reg <=
                                    (op == wire_host_pkg::OP_WRITE);
                                shift_reg    <= tx_reg;
                                load_slot((op == wire_host_pkg::OP_WRITE) ?
                                          tx_reg[0] : 1'b1);
                            end
                        endcase
                    end
                end
                ST_BYTE: begin
                    if (slot_done) begin
                        shift_reg <= {slot_sample, shift_reg[7:1]};
                        if (bit_idx_reg == 3'h7) begin
                            state_reg <= ST_IDLE;
                            if (!is_write_reg) begin
                                rx_reg <= {slot_sample, shift_reg[7:1]};
                            end
                        end else begin
                            bit_idx_reg <= bit_idx_reg + 3'h1;
                            start_reg   <= 1'b1;
                            load_slot(next_bit);
                        end
                    end
                end
                ST_TRIP: begin
                    if (slot_done) begin
                        unique case (step_reg)
                            2'h0: begin
                                trip_id_reg <= slot_sample;
                                step_reg    <= 2'h1;
                                start_reg   <= 1'b1;
                                load_slot(1'b1);
                            end
                            2'h1: begin
                                trip_cmp_reg <= slot_sample;
                                step_reg     <= 2'h2;
                                start_reg    <= 1'b1;
                                trip_chosen_reg <= (trip_id_reg != slot_sample)
                                                   ? trip_id_reg : dir_reg;
                                load_slot((trip_id_reg != slot_sample) ?
                                          trip_id_reg : dir_reg);
                            end
                            default: begin
                                step_reg  <= 2'h0;
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_RESET, ST_WAIT: begin
                    if (slot_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Cut a 32-bit cycle figure to the counter width.
    function automatic wire_host_pkg::cnt_t cw(input int unsigned v);
        cw = wire_host_pkg::cnt_t'(v);
    endfunction

    // Set timing for one bit slot at the present speed.
    task automatic load_slot(input logic b);
        if (fast_speed_flag) begin
            low_reg <= cw(b ? wire_host_pkg::W1_FAST_CYC
                            : wire_host_pkg::W0_FAST_CYC);
            smp_reg <= cw(wire_host_pkg::RDS_FAST_CYC);
            end_reg <= cw(wire_host_pkg::SLOT_FAST_CYC);
        end else begin
            low_reg <= cw(b ? W1_REG_L : W0_REG_P);
            smp_reg <= cw(RDS_REG_L);
            end_reg <= cw(SLOT_REG_P);
        end
    endtask

    // Presence result of the last reset window.
    always_ff @(posedge clk) begin
        if (rst) begin
            presence_reg <= 1'b0;
        end else if (state_reg == ST_RESET && slot_done) begin
            presence_reg <= !slot_sample;
        end
    end

    // Phase tracking: reset, then one identity command, then memory use.
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_reg <= wire_host_pkg::PH_NONE;
        end else if (state_reg == ST_RESET && slot_done) begin
            phase_reg <= slot_sample ? wire_host_pkg::PH_NONE
                                     : wire_host_pkg::PH_ROM;
        end else if (state_reg == ST_BYTE && slot_done &&
                     bit_idx_reg == 3'h7 && is_write_reg &&
                     phase_reg == wire_host_pkg::PH_ROM) begin
            phase_reg <= wire_host_pkg::PH_MEM;
        end
    end

    // Speed flag follows the identity command and the reset length.
    always_ff @(posedge clk) begin
        if (rst) begin
            fast_speed_flag <= 1'b0;
        end else if (state_reg == ST_IDLE && wr_ctrl && op_ok &&
                     op == wire_host_pkg::OP_RESET &&
                     (!fast_speed_flag ||
                      pwdata[wire_host_pkg::CTRL_LONG_BIT])) begin
            fast_speed_flag <= 1'b0;
        end else if (state_reg == ST_BYTE && slot_done &&
                     bit_idx_reg == 3'h7 && is_write_reg &&
                     phase_reg == wire_host_pkg::PH_ROM) begin
            // Fast skip or fast match as identity command selects fast speed.
            if (tx_reg == wire_host_pkg::ROM_FAST_SKIP ||
                tx_reg == wire_host_pkg::ROM_FAST_MATCH) begin
                fast_speed_flag <= 1'b1;
            end
        end
    end

endmodule

// ---- tb/wire_host_properties.sv ----
// Port assertions for the single-wire bus master.
`timescale 1ns/1ps
module wire_host_properties #(parameter int unsigned RST_REG_P = 200) (
    // Watched ports
    input wire logic        clk, rst, psel, penable, pready, pslverr,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        line_out, line_oe
);
    logic [20:0] run;
    logic        seen;
    // Counts the length of the current master low pulse.
    always_ff @(posedge clk) run <= (rst || !line_oe) ? '0 : run + 1'b1;
    // Notes that a reset pulse has gone out since reset.
    always_ff @(posedge clk) seen <= !rst && (seen || run >= RST_REG_P);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_drain_only: assert property (line_out == 1'b0)
        else $error("line driven high");
    a_idle_out: assert property (
        $fell(rst) |-> !line_oe && prdata == '0)
        else $error("busy after reset");
    a_low_cap: assert property (run <= 2 * RST_REG_P)
        else $error("low pulse too long");
    a_reset_first: assert property (
        $fell(line_oe) && !seen |-> run >= RST_REG_P)
        else $error("slot before reset");
    a_listen_gap: assert property (
        $fell(line_oe) && run >= RST_REG_P |-> !line_oe [*8])
        else $error("presence window cut");
    a_ready_now: assert property (psel && penable |-> pready)
        else $error("wait state");
    a_err_unmapped: assert property (
        psel && penable && paddr > 8'h0C |-> pslverr)
        else $error("no error on unmapped");
    a_err_mapped: assert property (
        psel && penable && paddr == 8'h0C |-> !pslverr)
        else $error("error on status");
    c_reset: cover property ($fell(line_oe) && run >= RST_REG_P);
    c_slot: cover property ($fell(line_oe) && run < RST_REG_P);
    c_unmapped: cover property (psel && penable && pslverr);
endmodule
bind wire_host wire_host_properties #(.RST_REG_P(RST_REG_P)) props (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .paddr(paddr), .prdata(prdata),
    .line_out(line_out), .line_oe(line_oe));

// ---- tb/wire_slave_model.sv ----
// Behavioural slave: presence answer and a stream of identity bits.
`timescale 1ns/1ps
module wire_slave_model #(
    parameter int unsigned RST_P  = 150,
    parameter logic [7:0]  FAMILY = 8'h5A // Arbitrary value.
) (
    input  wire logic clk,
    input  wire logic line,
    output logic      pull = 1'b0
);
    int          lo = 0, pc = 0, hold = 0;
    logic [15:0] sh = 16'hFFFF;
    // Long lows reset the model; other falling edges clock out a bit.
    always @(posedge clk) begin
        lo <= line ? 0 : lo + 1; // A reset may overlap a bit it pulls low.
        pc <= (pc > 0) ? pc - 1 : 0;
        hold <= (hold > 0) ? hold - 1 : 0;
        if (line && lo >= RST_P) begin
            pc <= 80;
            sh <= {FAMILY, 8'hFF};
        end else if (!line && !pull && lo == 0 && pc == 0) begin
            sh <= {1'b1, sh[15:1]};
            hold <= sh[0] ? 0 : 140;
        end
        pull <= (pc > 0 && pc <= 70) || hold > 1;
    end
endmodule

// ---- tb/wire_host_tb.sv ----
// Register-level test of the bus master against the slave model.
`timescale 1ns/1ps
module wire_host_tb;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, err, line_out, line_oe, pull;
    wire         line = !(line_oe || pull);
    int          fails = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    wire_host #(.RST_REG_P(200), .PRES_REG_P(60),
        .W0_REG_P(100), .SLOT_REG_P(150), .COPY_WAIT_P(300)) dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_in(line),
        .line_out(line_out), .line_oe(line_oe));
    wire_slave_model dev (.clk(clk), .line(line), .pull(pull));
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin fails++; end_of_test(); end
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    // Polls the status word until the line operation is over.
    task automatic idle();
        int n = 0;
        do begin
            xfer(0, 8'h0C, 0);
            n++;
        end while (rd[0] !== 1'b0 && n < 2000);
        if (n >= 2000) begin fails++; end_of_test(); end
    endtask
    task automatic op(input logic [31:0] c); xfer(1, 8'h00, c); idle(); endtask
    task automatic send(input logic [7:0] b);
        xfer(1, 8'h04, {24'h0, b});
        op(wire_host_pkg::OP_WRITE);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence: order, presence, commands, speed flag, search, errors.
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        xfer(0, 8'h0C, 0); chk("status", 0, rd);
        op(wire_host_pkg::OP_WRITE); chk("order", 32'h20, rd);
        op(wire_host_pkg::OP_RESET); chk("init", 32'h0A, rd);
        send(8'h33); chk("phase", 2, rd[4:3]);
        op(wire_host_pkg::OP_READ);
        xfer(0, 8'h08, 0); chk("id", 32'h5A, rd);
        xfer(1, 8'h04, 32'hA5); xfer(1, 8'h00, 2); xfer(1, 8'h00, 2);
        idle(); chk("refused", 1, rd[6]);
        op(1); send(8'h3C); chk("fast", 1, rd[2]);
        op(32'h201); chk("slow", 0, rd[2]);
        send(8'hF0); op(4); chk("triplet", 2, rd[9:7]);
        op(5); chk("wait", 32'h112, rd);
        xfer(0, 8'h10, 0); chk("slverr", 1, err);
        xfer(0, 8'h04, 0); chk("txdata", 32'hF0, rd);
        end_of_test();
    end
endmodule
